// ---- pkg/plgate_params.svh ----
// Constants for the pile-up and live-time gate logic
`ifndef PLGATE_PARAMS_SVH
`define PLGATE_PARAMS_SVH
`define PLGATE_CLK_MHZ         250
`define PLGATE_RATE_WIDTH_NS   100
`define PLGATE_RATE_CYCLES     ((`PLGATE_RATE_WIDTH_NS * `PLGATE_CLK_MHZ + 999) / 1000)
`define PLGATE_VETO_WIDTH_NS   100
`define PLGATE_VETO_CYCLES     ((`PLGATE_VETO_WIDTH_NS * `PLGATE_CLK_MHZ + 999) / 1000)
`define PLGATE_SYNC_STAGES     2
`endif

// ---- pkg/plgate_pkg.sv ----
// Types for the pile-up and live-time gate logic
package plgate_pkg;
  typedef enum logic [2:0] {
    PLGATE_LT_IDLE  = 3'b001,
    PLGATE_LT_ARMED = 3'b010,
    PLGATE_LT_GATE  = 3'b100
  } plgate_lt_state_t;

  typedef struct packed {
    logic fast_arrival;
    logic slow_over;
    logic accept;
  } plgate_in_t;
endpackage

// ---- design/plgate_top.sv ----
// Pile-up rejector and live-time gate logic
`timescale 1ns/100ps
`default_nettype none
`include "plgate_params.svh"
// -----------------------------------------------------------------------------
// Function
// - One count-rate pulse per fast discriminator arrival; arrivals within the pulse width merge into one pulse.
// - Busy stays high while slow discriminator is over threshold.
// - Busy is stretched to cover any pile-up inhibit.
// - Second arrival during busy retriggers busy and restarts the count pulse width.
// - First pulse sets pile-up flag; arrival while set raises inhibit.
// - After rejection and acceptance strobe, gate rises until next strobe.
// - Count-rate pulse lasts 25 cycles from the last arrival, nominally 100 ns.
// - Live-time gate is active high; high stops analyzer timer.
// -----------------------------------------------------------------------------
module plgate_top
  import plgate_pkg::*;
#(
  parameter int RATE_CYCLES = `PLGATE_RATE_CYCLES,
  parameter int VETO_CYCLES = `PLGATE_VETO_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic fast_arrival,
  input  wire logic slow_over,
  input  wire logic conversion_accept_strobe,
  output var  logic count_rate_pulse,
  output var  logic busy,
  output var  logic pileup_inhibit,
  output var  logic livetime_gate
);

  initial begin
    if (RATE_CYCLES < 1 || RATE_CYCLES > 255 || VETO_CYCLES < 1 || VETO_CYCLES > 255) begin
      $error("plgate_top: pulse widths must be 1..255 cycles");
    end
  end

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  plgate_in_t sync1_reg;
  plgate_in_t sync2_reg;
  plgate_in_t prev_reg;
  plgate_in_t in_now;

  assign in_now = '{fast_arrival: fast_arrival, slow_over: slow_over,
                    accept: conversion_accept_strobe};

  // First stage is read only by the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end else begin
      sync1_reg <= in_now;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  logic arrival_rise;
  logic accept_rise;
  assign arrival_rise = sync2_reg.fast_arrival & ~prev_reg.fast_arrival;
  assign accept_rise  = sync2_reg.accept & ~prev_reg.accept;

  // ---------------------------------------------------------------------------
  // Count-rate pulse
  // ---------------------------------------------------------------------------
  logic [7:0] rate_cnt_reg;

  // Retrigger restarts the width so close arrivals merge; a known limitation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_cnt_reg     <= 8'h00;
      count_rate_pulse <= 1'b0;
    end else if (arrival_rise) begin
      rate_cnt_reg     <= 8'(RATE_CYCLES - 1);
      count_rate_pulse <= 1'b1;
    end else if (rate_cnt_reg != 8'h00) begin
      rate_cnt_reg <= rate_cnt_reg - 8'h01;
    end else begin
      count_rate_pulse <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Pile-up flag and inhibit
  // ---------------------------------------------------------------------------
  logic       pileup_flag_reg;
  logic [7:0] veto_cnt_reg;
  logic       reject_event;
  logic       busy_next;

  assign reject_event = arrival_rise & pileup_flag_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pileup_flag_reg <= 1'b0;
    end else if (arrival_rise) begin
      pileup_flag_reg <= 1'b1;
    end else if (!busy_next) begin
      pileup_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      veto_cnt_reg   <= 8'h00;
      pileup_inhibit <= 1'b0;
    end else if (reject_event) begin
      veto_cnt_reg   <= 8'(VETO_CYCLES - 1);
      pileup_inhibit <= 1'b1;
    end else if (veto_cnt_reg != 8'h00) begin
      veto_cnt_reg <= veto_cnt_reg - 8'h01;
    end else if (!sync2_reg.slow_over) begin
      // Inhibit holds until the piled-up pulse falls below threshold
      pileup_inhibit <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Busy
  // ---------------------------------------------------------------------------
  assign busy_next = sync2_reg.slow_over | arrival_rise | reject_event
                   | (pileup_inhibit & (veto_cnt_reg != 8'h00 | sync2_reg.slow_over));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= busy_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Live-time gate
  // ---------------------------------------------------------------------------
  plgate_lt_state_t lt_state_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lt_state_reg  <= PLGATE_LT_IDLE;
      livetime_gate <= 1'b0;
    end else begin
      unique case (lt_state_reg)
        PLGATE_LT_IDLE: begin
          if (reject_event) begin
            lt_state_reg <= PLGATE_LT_ARMED;
          end
        end
        PLGATE_LT_ARMED: begin
          if (accept_rise) begin
            lt_state_reg  <= PLGATE_LT_GATE;
            livetime_gate <= 1'b1;
          end
        end
        PLGATE_LT_GATE: begin
          if (accept_rise) begin
            // A rejection coinciding with the closing strobe re-arms so the loss is still paid for
            lt_state_reg  <= reject_event ? PLGATE_LT_ARMED : PLGATE_LT_IDLE;
            livetime_gate <= 1'b0;
          end else if (reject_event) begin
            lt_state_reg <= PLGATE_LT_GATE;
          end
        end
        default: begin
          lt_state_reg  <= PLGATE_LT_IDLE;
          livetime_gate <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  // Cycles since the last arrival, saturating; long widths need no deep repetition
  logic [8:0] rate_age_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_age_reg <= 9'h1ff;
    end else if (arrival_rise) begin
      rate_age_reg <= 9'h001;
    end else if (rate_age_reg != 9'h1ff) begin
      rate_age_reg <= rate_age_reg + 9'h001;
    end
  end

  property p_rate_on_arrival;
    @(posedge clk) disable iff (rst) arrival_rise |=> count_rate_pulse;
  endproperty
  a_rate_on_arrival: assert property (p_rate_on_arrival) else $error("no count pulse");

  property p_rate_width;
    @(posedge clk) disable iff (rst)
      (rate_age_reg <= 9'(RATE_CYCLES)) |-> count_rate_pulse;
  endproperty
  a_rate_width: assert property (p_rate_width) else $error("count pulse short");

  property p_rate_ends;
    @(posedge clk) disable iff (rst)
      (rate_age_reg > 9'(RATE_CYCLES)) |-> !count_rate_pulse;
  endproperty
  a_rate_ends: assert property (p_rate_ends) else $error("count pulse long");

  property p_busy_over;
    @(posedge clk) disable iff (rst) sync2_reg.slow_over |=> busy;
  endproperty
  a_busy_over: assert property (p_busy_over) else $error("busy low over threshold");

  // Busy and inhibit fall on the same edge, so busy covers every inhibit cycle
  property p_busy_covers_veto;
    @(posedge clk) disable iff (rst) pileup_inhibit |-> busy;
  endproperty
  a_busy_covers_veto: assert property (p_busy_covers_veto) else $error("busy not stretched");

  property p_veto_on_pileup;
    @(posedge clk) disable iff (rst) reject_event |=> pileup_inhibit;
  endproperty
  a_veto_on_pileup: assert property (p_veto_on_pileup) else $error("no inhibit");

  property p_veto_cause;
    @(posedge clk) disable iff (rst) $rose(pileup_inhibit) |-> $past(reject_event);
  endproperty
  a_veto_cause: assert property (p_veto_cause) else $error("spurious inhibit");

  property p_gate_cause;
    @(posedge clk) disable iff (rst)
      $rose(livetime_gate) |-> $past(accept_rise) && $past(lt_state_reg) == PLGATE_LT_ARMED;
  endproperty
  a_gate_cause: assert property (p_gate_cause) else $error("gate without arming");

  property p_gate_hold;
    @(posedge clk) disable iff (rst) livetime_gate && !accept_rise |=> livetime_gate;
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gate dropped early");

  property p_gate_drop;
    @(posedge clk) disable iff (rst) livetime_gate && accept_rise |=> !livetime_gate;
  endproperty
  a_gate_drop: assert property (p_gate_drop) else $error("gate not dropped");

  property p_flag_clear;
    @(posedge clk) disable iff (rst) !busy_next && !arrival_rise |=> !pileup_flag_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag stuck");

  c_pileup: cover property (@(posedge clk) disable iff (rst) reject_event);
  c_gate_on: cover property (@(posedge clk) disable iff (rst) $rose(livetime_gate));
  c_gate_off: cover property (@(posedge clk) disable iff (rst) $fell(livetime_gate));
  c_single: cover property (@(posedge clk) disable iff (rst) $fell(busy) && !pileup_inhibit);

endmodule // plgate_top
`default_nettype wire

// ---- testbench/plgate_analyzer.sv ----
// Behavioural analyzer model facing the gate logic
`timescale 1ns/100ps
`default_nettype none
module plgate_analyzer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic        livetime_gate,
  input  wire logic        pileup_inhibit,
  output var  logic        conversion_accept_strobe,
  output var  logic [31:0] live_cycles,
  output var  logic [31:0] stored
);
  logic [1:0] hold_reg;
  // Two-cycle strobe so the synchroniser cannot miss it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) hold_reg <= 2'h0;
    else if (req) hold_reg <= 2'h2;
    else if (hold_reg != 2'h0) hold_reg <= hold_reg - 2'h1;
  end
  always_comb conversion_accept_strobe = (hold_reg != 2'h0);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) live_cycles <= 32'h0;
    else if (!livetime_gate) live_cycles <= live_cycles + 32'h1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) stored <= 32'h0;
    else if (req && !pileup_inhibit) stored <= stored + 32'h1;
  end
endmodule // plgate_analyzer
`default_nettype wire

// ---- testbench/plgate_top_tb.sv ----
// Self-checking bench for the pile-up and live-time gate logic
`timescale 1ns/100ps
`default_nettype none
module plgate_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        fa  = 1'b0;
  logic        so  = 1'b0;
  logic        req = 1'b0;
  logic        acc, crp, busy, veto, gate;
  logic [31:0] live, stored;
  int          mismatches = 0;
  int          checks_done = 0;
  plgate_top dut (.clk(clk), .rst(rst), .fast_arrival(fa), .slow_over(so),
    .conversion_accept_strobe(acc), .count_rate_pulse(crp), .busy(busy),
    .pileup_inhibit(veto), .livetime_gate(gate));
  plgate_analyzer analyzer_model (.clk(clk), .rst(rst), .req(req), .livetime_gate(gate),
    .pileup_inhibit(veto), .conversion_accept_strobe(acc), .live_cycles(live),
    .stored(stored));
  initial forever #2 clk = ~clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Width counted from the first high sample, bounded
  task automatic crp_width(input int exp);
    int n;
    n = 0;
    while (crp === 1'b1 && n < 40) begin
      n++;
      cyc(1);
    end
    check(n, exp);
    if (n == 40) print_verdict();
  endtask
  task automatic accept();
    req = 1'b1;
    cyc(1);
    req = 1'b0;
    cyc(7);
  endtask
  // ----------------------------------------
  // Single pulse, no pile-up
  // ----------------------------------------
  task automatic single_pulse();
    fa = 1'b1;
    so = 1'b1;
    cyc(1);
    fa = 1'b0;
    cyc(2);
    check(crp, 1'b1);
    check(busy, 1'b1);
    check(veto, 1'b0);
    crp_width(25);
    so = 1'b0;
    cyc(2);
    check(busy, 1'b1);
    cyc(2);
    check(busy, 1'b0);
    accept();
    check(gate, 1'b0);
  endtask
  // ----------------------------------------
  // Pile-up, rejection, gate cycle
  // ----------------------------------------
  task automatic pileup();
    logic [31:0] live_snap;
    fa = 1'b1;
    so = 1'b1;
    cyc(1);
    fa = 1'b0;
    cyc(9);
    fa = 1'b1;
    cyc(1);
    fa = 1'b0;
    cyc(3);
    check(crp, 1'b1);
    check(veto, 1'b1);
    so = 1'b0;
    cyc(8);
    check(busy, 1'b1);
    check(veto, 1'b1);
    cyc(30);
    check(veto, 1'b0);
    check(busy, 1'b0);
    check(gate, 1'b0);
    accept();
    check(gate, 1'b1);
    live_snap = live;
    cyc(10);
    check(live, live_snap);
    accept();
    check(gate, 1'b0);
    accept();
    check(gate, 1'b0);
    live_snap = live;
    cyc(10);
    check(live, live_snap + 32'h0000000a);
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    cyc(20);
    rst = 1'b0;
    cyc(2);
    single_pulse();
    cyc(5);
    pileup();
    print_verdict();
  end
endmodule // plgate_top_tb
`default_nettype wire
